/* rtl/etirc_pkg.sv */
package etirc_pkg;

  // position and converter widths
  localparam int unsigned STEP_W        = 12;
  localparam int unsigned TURN_W        = 12;
  localparam int unsigned POS_W         = STEP_W + TURN_W;
  localparam int unsigned DAC_W         = 12;
  localparam int unsigned MAX_TURNS     = 4096;
  localparam int unsigned STEPS_PER_REV = 4096;
  localparam int unsigned MAX_SPAN_DEG  = 1474560;
  localparam int unsigned DEF_RANGE_DEG = 3600;
  localparam int unsigned DEG_PER_REV   = 360;
  localparam logic [POS_W-1:0] DEF_SPAN = POS_W'(DEF_RANGE_DEG * STEPS_PER_REV / DEG_PER_REV);
  localparam logic [POS_W-1:0] DEF_ZERO = 24'h00_0000;
  localparam logic             DEF_SENSE = 1'b0;
  localparam logic [POS_W-1:0] MIN_SPAN = 24'h00_0001;

  // timing
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned HOLD_SET_MS = 1000;
  localparam int unsigned HOLD_SEQ_MS = 1500;
  localparam int unsigned GAP_MS      = 500;
  localparam int unsigned SKEW_MS     = 250;
  localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
  localparam int unsigned HOLD_SET_CYC = HOLD_SET_MS * CYC_PER_MS;
  localparam int unsigned HOLD_SEQ_CYC = HOLD_SEQ_MS * CYC_PER_MS;
  localparam int unsigned GAP_CYC      = GAP_MS * CYC_PER_MS;
  localparam int unsigned SKEW_CYC     = SKEW_MS * CYC_PER_MS;
  localparam int unsigned CNT_W        = 28;

  // register map
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ZERO   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SPAN   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_REL    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DAC    = 8'h14;
  localparam int unsigned CTRL_SENSE_BIT  = 0;
  localparam int unsigned ST_RANGE_BIT    = 0;
  localparam int unsigned ST_OVER_BIT     = 1;
  localparam int unsigned ST_UNDER_BIT    = 2;
  localparam int unsigned ST_ADJ_BIT      = 3;
  localparam int unsigned ST_ARMED_BIT    = 4;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_PRESS_A = 5'h02,
    ST_PRESS_B = 5'h04,
    ST_PRESS_AB = 5'h08,
    ST_WAIT_REL = 5'h10
  } etirc_state_t;

endpackage : etirc_pkg

/* rtl/etirc_div_if.sv */
`timescale 1ns/1ns
interface etirc_div_if;
  logic                          start;
  logic [etirc_pkg::POS_W-1:0]   num;
  logic [etirc_pkg::POS_W-1:0]   den;
  logic                          done;
  logic [etirc_pkg::DAC_W-1:0]   quot;
  modport master (output start, output num, output den, input done, input quot);
  modport slave  (input start, input num, input den, output done, output quot);
endinterface : etirc_div_if

/* rtl/etirc_sync.sv */
`timescale 1ns/1ns
module etirc_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // three stages per bit; a change counts once stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_q[i]      <= 1'b0;
        s2_q[i]      <= 1'b0;
        s3_q[i]      <= 1'b0;
        level_out[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin_in[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          level_out[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : etirc_sync

/* rtl/etirc_scale_div.sv */
`timescale 1ns/1ns
module etirc_scale_div (
  input  wire logic clk,
  input  wire logic rst_n,
  etirc_div_if.slave div
);
  logic [etirc_pkg::POS_W:0]   rem_q;
  logic [etirc_pkg::POS_W-1:0] den_q;
  logic [etirc_pkg::DAC_W-1:0] quot_q;
  logic [4:0]                  cnt_q;
  logic                        busy_q;
  logic                        done_q;
  logic [etirc_pkg::POS_W:0]   shifted;

  assign shifted   = {rem_q[etirc_pkg::POS_W-1:0], 1'b0};
  assign div.done  = done_q;
  assign div.quot  = quot_q;

  // fraction division: quot = floor(num * 4096 / den), num < den
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_q  <= '0;
      den_q  <= etirc_pkg::MIN_SPAN;
      quot_q <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (div.start && !busy_q) begin
        rem_q  <= {1'b0, div.num};
        den_q  <= div.den;
        quot_q <= '0;
        cnt_q  <= 5'(etirc_pkg::DAC_W);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (shifted >= {1'b0, den_q}) begin
          rem_q  <= shifted - {1'b0, den_q};
          quot_q <= {quot_q[etirc_pkg::DAC_W-2:0], 1'b1};
        end else begin
          rem_q  <= shifted;
          quot_q <= {quot_q[etirc_pkg::DAC_W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule : etirc_scale_div

/* rtl/etirc_top.sv */
// How it works
// (R1) position spans at most 4096 turns
// (R2) default measuring range is 3600 degrees
// (R3) outside range: symmetric overflow and underflow
// (R4) preset jumps to range centre, even outside
// (R5) 4096 steps per turn, 12-bit converter
// (R6) default sense counts up clockwise
// (R7) preset value is the range centre
// (R8) input zero alone 1 s sets zero
// (R9) input one alone 1 s sets end
// (R10) both inputs 1 s restore factory values
// (R11) zero 1.5 s, gap, one 1.5 s reverses
// (R12) two zero 1.5 s presses, gap: preset
// (R13) both inputs low ends adjustment mode
// (R14) partner keeps both-input skew within 0.25 s
// (R15) short presses never change stored values
// (R16) range scales linearly onto full converter span
`timescale 1ns/1ns
module etirc_top #(
  parameter int unsigned HOLD_SET_CYC = etirc_pkg::HOLD_SET_CYC,
  parameter int unsigned HOLD_SEQ_CYC = etirc_pkg::HOLD_SEQ_CYC,
  parameter int unsigned GAP_CYC      = etirc_pkg::GAP_CYC,
  parameter int unsigned SKEW_CYC     = etirc_pkg::SKEW_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          adjust_input_zero,
  input  wire logic                          adjust_input_one,
  input  wire logic [etirc_pkg::POS_W-1:0]   shaft_position,
  input  wire logic [etirc_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [etirc_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [etirc_pkg::DATA_W-1:0]  reg_rdata,
  output logic      [etirc_pkg::DAC_W-1:0]   dac_code,
  output logic                               range_ok,
  output logic                               overflow,
  output logic                               underflow,
  output logic                               adjust_mode
);
  localparam logic [etirc_pkg::CNT_W-1:0] HOLD_SET_N = etirc_pkg::CNT_W'(HOLD_SET_CYC);
  localparam logic [etirc_pkg::CNT_W-1:0] HOLD_SEQ_N = etirc_pkg::CNT_W'(HOLD_SEQ_CYC);
  localparam logic [etirc_pkg::CNT_W-1:0] GAP_N      = etirc_pkg::CNT_W'(GAP_CYC);
  localparam logic [etirc_pkg::CNT_W-1:0] SKEW_N     = etirc_pkg::CNT_W'(SKEW_CYC);

  logic [1:0]                        pins;
  logic                              in_a;
  logic                              in_b;
  etirc_pkg::etirc_state_t           state_q;
  logic [etirc_pkg::CNT_W-1:0]       hold_q;
  logic [etirc_pkg::CNT_W-1:0]       gap_q;
  logic                              armed_q;
  logic [etirc_pkg::POS_W-1:0]       arm_pos_q;
  logic                              sense_q;
  logic [etirc_pkg::POS_W-1:0]       zero_q;
  logic [etirc_pkg::POS_W-1:0]       span_q;
  logic [etirc_pkg::POS_W-1:0]       pos_eff;
  logic [etirc_pkg::POS_W-1:0]       rel;
  logic [etirc_pkg::POS_W-1:0]       new_span;
  logic [etirc_pkg::POS_W-1:0]       half_out;
  logic                              in_rng;
  logic                              in_ovf;
  logic                              same_pos;
  logic                              do_zero;
  logic                              do_end;
  logic                              do_default;
  logic                              do_reverse;
  logic                              do_preset;
  logic                              do_arm;
  logic                              do_disarm;
  logic                              wait_q;
  logic                              start_q;
  logic [etirc_pkg::POS_W-1:0]       num_q;
  logic                              conv_rng_q;
  logic                              conv_ovf_q;

  etirc_div_if div_bus ();

  etirc_sync #(
    .W (2)
  ) u_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin_in    ({adjust_input_one, adjust_input_zero}),
    .level_out (pins)
  );

  etirc_scale_div u_div (
    .clk   (clk),
    .rst_n (rst_n),
    .div   (div_bus.slave)
  );

  assign in_a = pins[0];
  assign in_b = pins[1];

  // position mapping
  assign pos_eff  = sense_q ? (etirc_pkg::POS_W)'(0 - shaft_position) : shaft_position; // see (R6)
  assign rel      = pos_eff - zero_q;                                   // see (R1)
  assign half_out = (etirc_pkg::POS_W)'((~span_q + 24'h00_0001) >> 1);  // see (R3)
  assign in_rng   = rel < span_q;
  assign in_ovf   = !in_rng && ((rel - span_q) < half_out);             // see (R3)
  assign new_span = (pos_eff == zero_q) ? etirc_pkg::MIN_SPAN : rel;
  assign same_pos = shaft_position == arm_pos_q;

  // adjustment decisions, taken on release of the pressed input; factory restore is taken while both inputs are still held
  always_comb begin
    do_zero    = 1'b0;
    do_end     = 1'b0;
    do_default = 1'b0;
    do_reverse = 1'b0;
    do_preset  = 1'b0;
    do_arm     = 1'b0;
    do_disarm  = 1'b0;
    case (state_q)
      etirc_pkg::ST_PRESS_A: begin
        if (!in_a && !in_b) begin
          do_disarm = 1'b1;
          if (hold_q >= HOLD_SEQ_N) begin
            if (armed_q && same_pos && gap_q >= GAP_N) begin
              do_preset = 1'b1;                                         // see (R12)
            end else begin
              do_arm = 1'b1;                                            // see (R11)
            end
          end else if (hold_q >= HOLD_SET_N) begin
            do_zero = 1'b1;                                             // see (R8)
          end
        end
      end
      etirc_pkg::ST_PRESS_B: begin
        if (!in_a && !in_b) begin
          do_disarm = 1'b1;
          if (hold_q >= HOLD_SEQ_N && armed_q && same_pos && gap_q >= GAP_N) begin
            do_reverse = 1'b1;                                          // see (R11)
          end else if (hold_q >= HOLD_SET_N) begin
            do_end = 1'b1;                                              // see (R9)
          end
        end
      end
      etirc_pkg::ST_PRESS_AB: begin
        if (in_a && in_b && hold_q == HOLD_SET_N) begin
          do_default = 1'b1;                                            // see (R10)
          do_disarm  = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end

  // adjustment sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= etirc_pkg::ST_IDLE;
    end else begin
      case (state_q)
        etirc_pkg::ST_IDLE: begin
          if (in_a && in_b) begin
            state_q <= etirc_pkg::ST_PRESS_AB;
          end else if (in_a) begin
            state_q <= etirc_pkg::ST_PRESS_A;
          end else if (in_b) begin
            state_q <= etirc_pkg::ST_PRESS_B;
          end
        end
        etirc_pkg::ST_PRESS_A: begin
          if (in_b && hold_q < SKEW_N && in_a) begin
            state_q <= etirc_pkg::ST_PRESS_AB;                          // see (R14)
          end else if (in_b) begin
            state_q <= etirc_pkg::ST_WAIT_REL;
          end else if (!in_a) begin
            state_q <= etirc_pkg::ST_IDLE;                              // see (R13)
          end
        end
        etirc_pkg::ST_PRESS_B: begin
          if (in_a && hold_q < SKEW_N && in_b) begin
            state_q <= etirc_pkg::ST_PRESS_AB;                          // see (R14)
          end else if (in_a) begin
            state_q <= etirc_pkg::ST_WAIT_REL;
          end else if (!in_b) begin
            state_q <= etirc_pkg::ST_IDLE;                              // see (R13)
          end
        end
        etirc_pkg::ST_PRESS_AB: begin
          if (do_default || !in_a || !in_b) begin
            state_q <= etirc_pkg::ST_WAIT_REL;                          // see (R15)
          end
        end
        etirc_pkg::ST_WAIT_REL: begin
          if (!in_a && !in_b) begin
            state_q <= etirc_pkg::ST_IDLE;                              // see (R13)
          end
        end
        default: begin
          state_q <= etirc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // hold time of the current press, restarted when the press pattern changes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
    end else if (state_q == etirc_pkg::ST_IDLE || state_q == etirc_pkg::ST_WAIT_REL) begin
      hold_q <= '0;
    end else if (state_q == etirc_pkg::ST_PRESS_A && in_b && in_a && hold_q < SKEW_N) begin
      hold_q <= '0;
    end else if (state_q == etirc_pkg::ST_PRESS_B && in_a && in_b && hold_q < SKEW_N) begin
      hold_q <= '0;
    end else if (hold_q != '1) begin
      hold_q <= hold_q + 1'b1;                                          // see (R15)
    end
  end

  // idle time between the two steps of a sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= '0;
    end else if (do_arm) begin
      gap_q <= '0;
    end else if (state_q == etirc_pkg::ST_IDLE && gap_q != '1) begin
      gap_q <= gap_q + 1'b1;                                            // see (R11)
    end
  end

  // first step of a two-step sequence, with the shaft position at its release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q   <= 1'b0;
      arm_pos_q <= '0;
    end else if (do_arm) begin
      armed_q   <= 1'b1;
      arm_pos_q <= shaft_position;                                      // see (R12)
    end else if (do_disarm) begin
      armed_q <= 1'b0;
    end
  end

  // stored parameters; a teach-in action wins over a bus write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_q <= etirc_pkg::DEF_SENSE;                                  // see (R6)
      zero_q  <= etirc_pkg::DEF_ZERO;
      span_q  <= etirc_pkg::DEF_SPAN;                                   // see (R2)
    end else if (do_default) begin
      sense_q <= etirc_pkg::DEF_SENSE;                                  // see (R10)
      zero_q  <= etirc_pkg::DEF_ZERO;
      span_q  <= etirc_pkg::DEF_SPAN;
    end else if (do_zero) begin
      zero_q <= pos_eff;                                                // see (R8)
    end else if (do_end) begin
      span_q <= new_span;                                               // see (R9)
    end else if (do_reverse) begin
      sense_q <= !sense_q;                                              // see (R11)
      zero_q  <= (etirc_pkg::POS_W)'(0 - (zero_q + span_q));
    end else if (do_preset) begin
      zero_q <= pos_eff - (span_q >> 1);                                // see (R4) (R7)
    end else if (reg_wr) begin
      if (reg_addr == etirc_pkg::OFS_CTRL) begin
        sense_q <= reg_wdata[etirc_pkg::CTRL_SENSE_BIT];
      end else if (reg_addr == etirc_pkg::OFS_ZERO) begin
        zero_q <= reg_wdata[etirc_pkg::POS_W-1:0];
      end else if (reg_addr == etirc_pkg::OFS_SPAN) begin
        if (reg_wdata[etirc_pkg::POS_W-1:0] != '0) begin
          span_q <= reg_wdata[etirc_pkg::POS_W-1:0];
        end
      end
    end
  end

  // conversion loop: sample, divide, load the output code
  assign div_bus.start = start_q;
  assign div_bus.num   = num_q;
  assign div_bus.den   = span_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q     <= 1'b0;
      start_q    <= 1'b0;
      num_q      <= '0;
      conv_rng_q <= 1'b0;
      conv_ovf_q <= 1'b0;
    end else if (!wait_q) begin
      wait_q     <= 1'b1;
      start_q    <= 1'b1;
      num_q      <= in_rng ? rel : '0;
      conv_rng_q <= in_rng;
      conv_ovf_q <= in_ovf;
    end else begin
      start_q <= 1'b0;
      if (div_bus.done) begin
        wait_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_code  <= '0;
      range_ok  <= 1'b0;
      overflow  <= 1'b0;
      underflow <= 1'b0;
    end else if (div_bus.done) begin
      range_ok  <= conv_rng_q;
      overflow  <= conv_ovf_q;
      underflow <= !conv_rng_q && !conv_ovf_q;
      if (conv_rng_q) begin
        dac_code <= div_bus.quot;                                       // see (R5) (R16)
      end else if (conv_ovf_q) begin
        dac_code <= '1;                                                 // see (R3)
      end else begin
        dac_code <= '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adjust_mode <= 1'b0;
    end else begin
      adjust_mode <= in_a || in_b || state_q != etirc_pkg::ST_IDLE;    // see (R13)
    end
  end

  // register read port, data in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == etirc_pkg::OFS_CTRL) begin
      reg_rdata <= etirc_pkg::DATA_W'(sense_q);
    end else if (reg_addr == etirc_pkg::OFS_ZERO) begin
      reg_rdata <= etirc_pkg::DATA_W'(zero_q);
    end else if (reg_addr == etirc_pkg::OFS_SPAN) begin
      reg_rdata <= etirc_pkg::DATA_W'(span_q);
    end else if (reg_addr == etirc_pkg::OFS_STATUS) begin
      reg_rdata <= etirc_pkg::DATA_W'({armed_q, adjust_mode, underflow, overflow, range_ok});
    end else if (reg_addr == etirc_pkg::OFS_REL) begin
      reg_rdata <= etirc_pkg::DATA_W'(rel);
    end else if (reg_addr == etirc_pkg::OFS_DAC) begin
      reg_rdata <= etirc_pkg::DATA_W'(dac_code);
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : etirc_top

/* sim/etirc_sva.sv */
`timescale 1ns/1ns
module etirc_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        adjust_input_zero,
  input wire logic        adjust_input_one,
  input wire logic [23:0] shaft_position,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [11:0] dac_code,
  input wire logic        range_ok,
  input wire logic        overflow,
  input wire logic        underflow,
  input wire logic        adjust_mode
);
  logic [3:0] since_q;
  // cycles since either adjust input was last high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) since_q <= 4'h0;
    else if (adjust_input_zero || adjust_input_one) since_q <= 4'h0;
    else if (since_q != 4'hF) since_q <= since_q + 4'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read cycle");
  a_region_onehot: assert property ($onehot0({range_ok, overflow, underflow}))
    else $error("more than one region flag high");
  a_over_full: assert property (overflow |-> dac_code == 12'hFFF)
    else $error("overflow without full code");
  a_under_zero: assert property (underflow |-> dac_code == 12'h000)
    else $error("underflow without zero code");
  a_status_read: assert property (reg_rd && reg_addr == etirc_pkg::OFS_STATUS |=>
    reg_rdata[3:0] == $past({adjust_mode, underflow, overflow, range_ok}))
    else $error("status read mismatch");
  a_dac_read: assert property (reg_rd && reg_addr == etirc_pkg::OFS_DAC |=> reg_rdata == {20'h0_0000, $past(dac_code)})
    else $error("converter code read mismatch");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'hFC |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_mode_on_input: assert property (adjust_input_zero [*6] |-> adjust_mode)
    else $error("adjust mode low while input held");
  a_mode_cause: assert property ($rose(adjust_mode) |-> since_q < 4'h8)
    else $error("adjust mode rose without input");
endmodule : etirc_sva

bind etirc_top etirc_sva u_sva (
  .clk(clk), .rst_n(rst_n), .adjust_input_zero(adjust_input_zero), .adjust_input_one(adjust_input_one),
  .shaft_position(shaft_position), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dac_code(dac_code), .range_ok(range_ok),
  .overflow(overflow), .underflow(underflow), .adjust_mode(adjust_mode));

/* sim/etirc_prog_model.sv */
`timescale 1ns/1ns
module etirc_prog_model (
  input  wire logic clk,
  output logic      adjust_input_zero,
  output logic      adjust_input_one
);
  initial begin
    adjust_input_zero = 1'b0;
    adjust_input_one  = 1'b0;
  end
  // both levels change on one edge, so skew is zero
  task automatic press(input logic z, input logic o, input int cyc);
    @(posedge clk);
    adjust_input_zero <= z;
    adjust_input_one  <= o;
    repeat (cyc) @(posedge clk);
    adjust_input_zero <= 1'b0;
    adjust_input_one  <= 1'b0;
  endtask : press
  // input one joins lag cycles after input zero
  task automatic press_lag(input int lag, input int cyc);
    @(posedge clk);
    adjust_input_zero <= 1'b1;
    repeat (lag) @(posedge clk);
    adjust_input_one <= 1'b1;
    repeat (cyc) @(posedge clk);
    adjust_input_zero <= 1'b0;
    adjust_input_one  <= 1'b0;
  endtask : press_lag
endmodule : etirc_prog_model

/* sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  typedef struct {logic [23:0] pos; logic [11:0] code; logic [2:0] rg;} etirc_row_t;
  logic        clk;
  logic        rst_n;
  logic [23:0] shaft_position;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [11:0] dac_code;
  logic        range_ok;
  logic        overflow;
  logic        underflow;
  logic        adjust_mode;
  logic        in_zero;
  logic        in_one;
  logic [31:0] d;
  int          mismatches;
  int          checked;
  etirc_row_t  rows [8];

  etirc_prog_model prog (.clk(clk), .adjust_input_zero(in_zero), .adjust_input_one(in_one));
  etirc_top #(.HOLD_SET_CYC(100), .HOLD_SEQ_CYC(150), .GAP_CYC(50), .SKEW_CYC(10)) uut (
    .clk(clk), .rst_n(rst_n), .adjust_input_zero(in_zero), .adjust_input_one(in_one),
    .shaft_position(shaft_position), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dac_code(dac_code), .range_ok(range_ok),
    .overflow(overflow), .underflow(underflow), .adjust_mode(adjust_mode));

  always #5 clk = ~clk;

  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic settle();
    repeat (32) @(posedge clk);
    #1;
  endtask : settle
  task automatic wait_idle();
    int n;
    n = 0;
    while (adjust_mode !== 1'b0 && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 300) begin
      mismatches++;
      complete_run();
    end
  endtask : wait_idle

  initial begin
    rows = '{'{24'h00_0000, 12'h000, 3'b001}, '{24'h00_000A, 12'h001, 3'b001},
             '{24'h00_5000, 12'h800, 3'b001}, '{24'h00_9FFF, 12'hFFF, 3'b001},
             '{24'h00_A000, 12'hFFF, 3'b010}, '{24'h80_0000, 12'hFFF, 3'b010},
             '{24'h80_5000, 12'h000, 3'b100}, '{24'hFF_FFFF, 12'h000, 3'b100}};
    clk = 1'b0;
    rst_n = 1'b0;
    shaft_position = 24'h00_0000;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(etirc_pkg::OFS_CTRL, d); chk("ctrl", d, 32'h0000_0000);
    rd(etirc_pkg::OFS_ZERO, d); chk("zero", d, 32'h0000_0000);
    rd(8'hFC, d); chk("unmapped", d, 32'h0000_0000);
    wr(etirc_pkg::OFS_SPAN, 32'h0000_0000);
    rd(etirc_pkg::OFS_SPAN, d); chk("span", d, 32'h0000_A000);
    foreach (rows[i]) begin
      shaft_position <= rows[i].pos;
      settle();
      chk("dac", {20'h0_0000, dac_code}, {20'h0_0000, rows[i].code});
      chk("region", {29'h0, underflow, overflow, range_ok}, {29'h0, rows[i].rg});
    end
    shaft_position <= 24'h00_1234;
    prog.press(1'b1, 1'b0, 50);
    wait_idle();
    rd(etirc_pkg::OFS_ZERO, d); chk("zero short", d, 32'h0000_0000);
    shaft_position <= 24'h00_1000;
    prog.press(1'b1, 1'b0, 120);
    wait_idle();
    rd(etirc_pkg::OFS_ZERO, d); chk("zero set", d, 32'h0000_1000);
    chk("mode", {31'h0, adjust_mode}, 32'h0000_0000);
    shaft_position <= 24'h00_3000;
    prog.press(1'b0, 1'b1, 120);
    wait_idle();
    rd(etirc_pkg::OFS_SPAN, d); chk("end set", d, 32'h0000_2000);
    shaft_position <= 24'h00_2000;
    settle();
    chk("dac mid", {20'h0_0000, dac_code}, 32'h0000_0800);
    shaft_position <= 24'h00_5000;
    settle();
    chk("over", {31'h0, overflow}, 32'h0000_0001);
    prog.press(1'b1, 1'b0, 160);
    repeat (60) @(posedge clk);
    prog.press(1'b1, 1'b0, 160);
    wait_idle();
    rd(etirc_pkg::OFS_ZERO, d); chk("preset", d, 32'h0000_4000);
    settle();
    chk("dac preset", {20'h0_0000, dac_code}, 32'h0000_0800);
    rd(etirc_pkg::OFS_DAC, d); chk("dac read", d, 32'h0000_0800);
    rd(etirc_pkg::OFS_STATUS, d); chk("status", d, 32'h0000_0001);
    rd(etirc_pkg::OFS_REL, d); chk("rel", d, 32'h0000_1000);
    prog.press(1'b1, 1'b0, 160);
    repeat (60) @(posedge clk);
    prog.press(1'b0, 1'b1, 160);
    wait_idle();
    rd(etirc_pkg::OFS_CTRL, d); chk("sense", d, 32'h0000_0001);
    rd(etirc_pkg::OFS_ZERO, d); chk("zero rev", d, 32'h00FF_A000);
    settle();
    chk("dac rev", {20'h0_0000, dac_code}, 32'h0000_0800);
    prog.press(1'b1, 1'b1, 110);
    wait_idle();
    rd(etirc_pkg::OFS_CTRL, d); chk("def ctrl", d, 32'h0000_0000);
    rd(etirc_pkg::OFS_ZERO, d); chk("def zero", d, 32'h0000_0000);
    rd(etirc_pkg::OFS_SPAN, d); chk("def span", d, 32'h0000_A000);
    wr(etirc_pkg::OFS_ZERO, 32'h0000_0123);
    prog.press_lag(20, 120);
    wait_idle();
    rd(etirc_pkg::OFS_ZERO, d); chk("late join", d, 32'h0000_0123);
    prog.press_lag(5, 120);
    wait_idle();
    rd(etirc_pkg::OFS_ZERO, d); chk("skew join", d, 32'h0000_0000);
    settle();
    wr(etirc_pkg::OFS_SPAN, 32'h0000_0400);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("rst dac", {20'h0_0000, dac_code}, 32'h0000_0000);
    chk("rst region", {29'h0, underflow, overflow, range_ok}, 32'h0000_0000);
    chk("rst mode", {31'h0, adjust_mode}, 32'h0000_0000);
    @(posedge clk);
    rst_n <= 1'b1;
    rd(etirc_pkg::OFS_SPAN, d); chk("rst span", d, 32'h0000_A000);
    settle();
    chk("rst resume", {20'h0_0000, dac_code}, 32'h0000_0800);
    complete_run();
  end
endmodule : tb_top
